/* inc/acc_xfer_pkg.sv */
// shared constants and types for the accumulator control-register transfer block
package acc_xfer_pkg;

  // ==========================================================================
  // widths
  localparam int INSTR_W = 10;
  localparam int NIB_W   = 4;
  localparam int PAGE_W  = 3;
  localparam int CFG_N   = 10;

  // ==========================================================================
  // instruction codes, full ten-bit words
  localparam logic [INSTR_W-1:0] CODE_READ_PULLUP_2   = 10'h25F;
  localparam logic [INSTR_W-1:0] CODE_WRITE_DISPLAY_A = 10'h2A8;
  localparam logic [INSTR_W-1:0] CODE_WRITE_DISPLAY_B = 10'h2A9;
  localparam logic [INSTR_W-1:0] CODE_WRITE_DISPLAY_C = 10'h226;
  localparam logic [INSTR_W-1:0] CODE_WRITE_DISPLAY_D = 10'h20A;
  localparam logic [INSTR_W-1:0] CODE_WRITE_PAGE      = 10'h029;
  localparam logic [INSTR_W-1:0] CODE_READ_PAGE       = 10'h051;
  localparam logic [INSTR_W-1:0] CODE_WRITE_DRIVE     = 10'h22B;
  localparam logic [INSTR_W-1:0] CODE_WRITE_IRQ       = 10'h217;
  localparam logic [INSTR_W-1:0] CODE_WRITE_WAKEUP_0  = 10'h21B;
  localparam logic [INSTR_W-1:0] CODE_WRITE_WAKEUP_1  = 10'h214;
  localparam logic [INSTR_W-1:0] CODE_WRITE_WAKEUP_2  = 10'h215;
  localparam logic [INSTR_W-1:0] CODE_WRITE_WAKEUP_3  = 10'h22C;

  // ==========================================================================
  // decoded operation, one-hot
  typedef enum logic [13:0] {
    OP_NONE                  = 14'b00_0000_0000_0000,
    OP_READ_PULLUP_CTRL_2    = 14'b00_0000_0000_0001,
    OP_WRITE_DISPLAY_CFG_A   = 14'b00_0000_0000_0010,
    OP_WRITE_DISPLAY_CFG_B   = 14'b00_0000_0000_0100,
    OP_WRITE_DISPLAY_CFG_C   = 14'b00_0000_0000_1000,
    OP_WRITE_DISPLAY_CFG_D   = 14'b00_0000_0001_0000,
    OP_WRITE_PAGE_POINTER    = 14'b00_0000_0010_0000,
    OP_WRITE_DRIVE_STRUCTURE = 14'b00_0000_0100_0000,
    OP_WRITE_IRQ_CFG         = 14'b00_0000_1000_0000,
    OP_WRITE_WAKEUP_CFG_0    = 14'b00_0001_0000_0000,
    OP_WRITE_WAKEUP_CFG_1    = 14'b00_0010_0000_0000,
    OP_WRITE_WAKEUP_CFG_2    = 14'b00_0100_0000_0000,
    OP_WRITE_WAKEUP_CFG_3    = 14'b00_1000_0000_0000,
    OP_READ_PAGE_POINTER     = 14'b01_0000_0000_0000
  } op_type;

  // ==========================================================================
  // bank slots of the configuration registers
  localparam int SLOT_DISPLAY_A = 0;
  localparam int SLOT_DISPLAY_B = 1;
  localparam int SLOT_DISPLAY_C = 2;
  localparam int SLOT_DISPLAY_D = 3;
  localparam int SLOT_IRQ       = 4;
  localparam int SLOT_DRIVE     = 5;
  localparam int SLOT_WAKEUP_0  = 6;
  localparam int SLOT_WAKEUP_1  = 7;
  localparam int SLOT_WAKEUP_2  = 8;
  localparam int SLOT_WAKEUP_3  = 9;

  // highest slot first so that a cast of the bank lines up
  typedef struct packed {
    logic [NIB_W-1:0] wakeup_cfg_3;
    logic [NIB_W-1:0] wakeup_cfg_2;
    logic [NIB_W-1:0] wakeup_cfg_1;
    logic [NIB_W-1:0] wakeup_cfg_0;
    logic [NIB_W-1:0] port_drive_structure_sel;
    logic [NIB_W-1:0] irq_cfg_reg;
    logic [NIB_W-1:0] display_cfg_d;
    logic [NIB_W-1:0] display_cfg_c;
    logic [NIB_W-1:0] display_cfg_b;
    logic [NIB_W-1:0] display_cfg_a;
  } cfg_out_type;

  // latched ahb address phase
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        valid;
  } ahb_req_type;

  // ==========================================================================
  // reset values
  localparam logic [NIB_W-1:0]  NIB_RESET  = 4'h0;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0;

  // ==========================================================================
  // ahb register byte addresses
  localparam logic [31:0] ADDR_ACC       = 32'h0000_0000;
  localparam logic [31:0] ADDR_PULLUP_2  = 32'h0000_0004;
  localparam logic [31:0] ADDR_PAGE      = 32'h0000_0008;
  localparam logic [31:0] ADDR_DISPLAY   = 32'h0000_000C;
  localparam logic [31:0] ADDR_WAKEUP    = 32'h0000_0010;
  localparam logic [31:0] ADDR_PORT_IRQ  = 32'h0000_0014;
  localparam logic [31:0] ADDR_LAST_OP   = 32'h0000_0018;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic        HRESP_OKAY     = 1'b0;

endpackage : acc_xfer_pkg

/* logic/xfer_decoder.sv */
// full-word decoder of the accumulator transfer instructions
`timescale 1ns/1ps
`default_nettype none
module xfer_decoder
  import acc_xfer_pkg::*;
(
  // fetched word
  input  wire logic               valid,
  input  wire logic [INSTR_W-1:0] word,
  // decoded operation
  output op_type                  op
);

  // ==========================================================================
  // decode
  always_comb begin
    op = OP_NONE;
    if (valid) begin
      // every bit of the word takes part, so aliases never match
      case (word)
        CODE_READ_PULLUP_2:   op = OP_READ_PULLUP_CTRL_2;
        CODE_WRITE_DISPLAY_A: op = OP_WRITE_DISPLAY_CFG_A;
        CODE_WRITE_DISPLAY_B: op = OP_WRITE_DISPLAY_CFG_B;
        CODE_WRITE_DISPLAY_C: op = OP_WRITE_DISPLAY_CFG_C;
        CODE_WRITE_DISPLAY_D: op = OP_WRITE_DISPLAY_CFG_D;
        CODE_WRITE_PAGE:      op = OP_WRITE_PAGE_POINTER;
        CODE_READ_PAGE:       op = OP_READ_PAGE_POINTER;
        CODE_WRITE_DRIVE:     op = OP_WRITE_DRIVE_STRUCTURE;
        CODE_WRITE_IRQ:       op = OP_WRITE_IRQ_CFG;
        CODE_WRITE_WAKEUP_0:  op = OP_WRITE_WAKEUP_CFG_0;
        CODE_WRITE_WAKEUP_1:  op = OP_WRITE_WAKEUP_CFG_1;
        CODE_WRITE_WAKEUP_2:  op = OP_WRITE_WAKEUP_CFG_2;
        CODE_WRITE_WAKEUP_3:  op = OP_WRITE_WAKEUP_CFG_3;
        default:              op = OP_NONE;
      endcase
    end
  end

endmodule : xfer_decoder
`default_nettype wire

/* logic/nibble_bank.sv */
// bank of small write-only-by-core configuration registers
`timescale 1ns/1ps
`default_nettype none
module nibble_bank
  import acc_xfer_pkg::*;
#(
  parameter int COUNT = CFG_N,
  parameter int WIDTH = NIB_W
) (
  // clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // write side
  input  wire logic [COUNT-1:0]            we,
  input  wire logic [WIDTH-1:0]            wdata,
  // contents
  output logic      [COUNT-1:0][WIDTH-1:0] q
);

  logic [COUNT-1:0][WIDTH-1:0] d;

  // ==========================================================================
  // one register per slot
  for (genvar i = 0; i < COUNT; i++) begin : g_slot
    always_comb begin
      d[i] = we[i] ? wdata : q[i];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        q[i] <= WIDTH'(NIB_RESET);
      end else begin
        q[i] <= d[i];
      end
    end
  end

endmodule : nibble_bank
`default_nettype wire

/* logic/acc_ctrl_reg_transfer_decode.sv */
// accumulator to control-register transfer execution with ahb-lite register access
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_reg_transfer_decode
  import acc_xfer_pkg::*;
(
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // instruction words from the sequencer
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr_word,
  // core state
  output logic      [NIB_W-1:0]   acc_q,
  output logic      [PAGE_W-1:0]  page_ptr_q,
  output logic                    exec_done_q,
  output logic                    skip_next_q,
  output logic                    carry_we_q,
  // configuration registers
  output cfg_out_type             cfg_out
);

  // ==========================================================================
  // declarations
  op_type                       op;
  logic [CFG_N-1:0]             bank_we;
  logic [CFG_N-1:0][NIB_W-1:0]  bank_q;
  logic [NIB_W-1:0]             acc_d;
  logic [NIB_W-1:0]             pullup_2_q;
  logic [NIB_W-1:0]             pullup_2_d;
  logic [PAGE_W-1:0]            page_ptr_d;
  logic                         exec_done_d;
  op_type                       last_op_q;
  op_type                       last_op_d;
  ahb_req_type                  req_q;
  ahb_req_type                  req_d;
  logic [31:0]                  hrdata_d;
  logic                         unused_hsize;

  assign unused_hsize = ^hsize;

  // ==========================================================================
  // decoder and configuration bank
  xfer_decoder u_dec (
    .valid (instr_valid),
    .word  (instr_word),
    .op    (op)
  );

  nibble_bank #(
    .COUNT (CFG_N),
    .WIDTH (NIB_W)
  ) u_bank (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (bank_we),
    .wdata   (acc_q),
    .q       (bank_q)
  );

  assign cfg_out = cfg_out_type'(bank_q);

  // ==========================================================================
  // execution
  always_comb begin
    bank_we     = '0;
    acc_d       = acc_q;
    pullup_2_d  = pullup_2_q;
    page_ptr_d  = page_ptr_q;
    exec_done_d = (op != OP_NONE);
    last_op_d   = (op != OP_NONE) ? op : last_op_q;
    // software writes land first; a same-cycle pull-up or page read instruction overrides the accumulator
    if (req_q.valid && req_q.write) begin
      if (req_q.addr == ADDR_ACC) begin
        acc_d = hwdata[NIB_W-1:0];
      end
      if (req_q.addr == ADDR_PULLUP_2) begin
        pullup_2_d = hwdata[NIB_W-1:0];
      end
    end
    case (op)
      OP_READ_PULLUP_CTRL_2:    acc_d = pullup_2_q;
      OP_WRITE_DISPLAY_CFG_A:   bank_we[SLOT_DISPLAY_A] = 1'b1;
      OP_WRITE_DISPLAY_CFG_B:   bank_we[SLOT_DISPLAY_B] = 1'b1;
      OP_WRITE_DISPLAY_CFG_C:   bank_we[SLOT_DISPLAY_C] = 1'b1;
      OP_WRITE_DISPLAY_CFG_D:   bank_we[SLOT_DISPLAY_D] = 1'b1;
      OP_WRITE_PAGE_POINTER:    page_ptr_d = acc_q[PAGE_W-1:0];
      OP_READ_PAGE_POINTER:     acc_d = {1'b0, page_ptr_q};
      OP_WRITE_DRIVE_STRUCTURE: bank_we[SLOT_DRIVE] = 1'b1;
      OP_WRITE_IRQ_CFG:         bank_we[SLOT_IRQ] = 1'b1;
      OP_WRITE_WAKEUP_CFG_0:    bank_we[SLOT_WAKEUP_0] = 1'b1;
      OP_WRITE_WAKEUP_CFG_1:    bank_we[SLOT_WAKEUP_1] = 1'b1;
      OP_WRITE_WAKEUP_CFG_2:    bank_we[SLOT_WAKEUP_2] = 1'b1;
      OP_WRITE_WAKEUP_CFG_3:    bank_we[SLOT_WAKEUP_3] = 1'b1;
      default:                  bank_we = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q       <= NIB_RESET;
      pullup_2_q  <= NIB_RESET;
      page_ptr_q  <= PAGE_RESET;
      exec_done_q <= 1'b0;
      skip_next_q <= 1'b0;
      carry_we_q  <= 1'b0;
      last_op_q   <= OP_NONE;
    end else begin
      acc_q       <= acc_d;
      pullup_2_q  <= pullup_2_d;
      page_ptr_q  <= page_ptr_d;
      exec_done_q <= exec_done_d;
      // no transfer here skips or writes carry; held low for the sequencer
      skip_next_q <= 1'b0;
      carry_we_q  <= 1'b0;
      last_op_q   <= last_op_d;
    end
  end

  // ==========================================================================
  // ahb-lite slave, zero wait states
  always_comb begin
    req_d.valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);
    req_d.write = hwrite;
    req_d.addr  = haddr;
    hrdata_d    = '0;
    // read data is built at the address phase; next values give write forwarding
    if (req_d.valid && !hwrite) begin
      case (haddr)
        ADDR_ACC:      hrdata_d = 32'(acc_d);
        ADDR_PULLUP_2: hrdata_d = 32'(pullup_2_d);
        ADDR_PAGE:     hrdata_d = 32'(page_ptr_d);
        ADDR_DISPLAY:  hrdata_d = 32'({cfg_out.display_cfg_d, cfg_out.display_cfg_c,
                                       cfg_out.display_cfg_b, cfg_out.display_cfg_a});
        ADDR_WAKEUP:   hrdata_d = 32'({cfg_out.wakeup_cfg_3, cfg_out.wakeup_cfg_2,
                                       cfg_out.wakeup_cfg_1, cfg_out.wakeup_cfg_0});
        ADDR_PORT_IRQ: hrdata_d = 32'({cfg_out.port_drive_structure_sel,
                                       cfg_out.irq_cfg_reg});
        ADDR_LAST_OP:  hrdata_d = 32'(last_op_d);
        default:       hrdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q     <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      req_q     <= req_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // ==========================================================================
  // checks
  // decode checks use raw words so that a broken decoder cannot hide behind op; single_cycle_a keys on op
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence page_write_s;
    instr_valid && instr_word == CODE_WRITE_PAGE;
  endsequence

  sequence page_read_s;
    instr_valid && instr_word == CODE_READ_PAGE;
  endsequence

  sequence acc_bus_write_s;
    req_q.valid && req_q.write && req_q.addr == ADDR_ACC;
  endsequence

  pullup_read_a: assert property (
    instr_valid && instr_word == CODE_READ_PULLUP_2 |=> acc_q == $past(pullup_2_q))
    else $error("accumulator not loaded from pull-up register");

  display_a_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_DISPLAY_A |=> cfg_out.display_cfg_a == $past(acc_q))
    else $error("display register a not written");

  display_c_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_DISPLAY_C |=> cfg_out.display_cfg_c == $past(acc_q))
    else $error("display register c not written");

  page_write_a: assert property (
    page_write_s |=> page_ptr_q == $past(acc_q[PAGE_W-1:0]))
    else $error("page pointer not written from accumulator");

  page_round_trip_a: assert property (
    page_write_s ##1 page_read_s |=> acc_q == {1'b0, $past(acc_q[PAGE_W-1:0], 2)})
    else $error("page pointer round trip wrong or bit 3 set");

  irq_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_IRQ |=> cfg_out.irq_cfg_reg == $past(acc_q)
      && $stable(cfg_out.port_drive_structure_sel))
    else $error("interrupt register write wrong");

  wakeup_3_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_WAKEUP_3 |=> cfg_out.wakeup_cfg_3 == $past(acc_q)
      && $stable(cfg_out.wakeup_cfg_0))
    else $error("wakeup register 3 write wrong");

  single_cycle_a: assert property (
    op != OP_NONE |=> exec_done_q && !skip_next_q && !carry_we_q)
    else $error("transfer did not complete in one cycle cleanly");

  full_compare_a: assert property (
    instr_valid && instr_word[7:0] == CODE_WRITE_DISPLAY_D[7:0]
      && instr_word != CODE_WRITE_DISPLAY_D |=> $stable(cfg_out.display_cfg_d))
    else $error("partial word match wrote display register d");

  display_b_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_DISPLAY_B |=> cfg_out.display_cfg_b == $past(acc_q))
    else $error("display register b not written");

  display_d_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_DISPLAY_D |=> cfg_out.display_cfg_d == $past(acc_q))
    else $error("display register d not written");

  drive_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_DRIVE
      |=> cfg_out.port_drive_structure_sel == $past(acc_q) && $stable(cfg_out.irq_cfg_reg))
    else $error("drive structure register write wrong");

  wakeup_0_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_WAKEUP_0 |=> cfg_out.wakeup_cfg_0 == $past(acc_q))
    else $error("wakeup register 0 not written");

  wakeup_1_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_WAKEUP_1 |=> cfg_out.wakeup_cfg_1 == $past(acc_q))
    else $error("wakeup register 1 not written");

  wakeup_2_write_a: assert property (
    instr_valid && instr_word == CODE_WRITE_WAKEUP_2 |=> cfg_out.wakeup_cfg_2 == $past(acc_q))
    else $error("wakeup register 2 not written");

  page_read_a: assert property (
    page_read_s |=> acc_q == {1'b0, $past(page_ptr_q)})
    else $error("accumulator not loaded from page pointer with bit 3 clear");

  // aliases share the low eight bits with a real code and must do nothing
  display_a_alias_a: assert property (
    instr_valid && instr_word[7:0] == CODE_WRITE_DISPLAY_A[7:0]
      && instr_word != CODE_WRITE_DISPLAY_A |=> $stable(cfg_out.display_cfg_a))
    else $error("partial word match wrote display register a");

  display_b_alias_a: assert property (
    instr_valid && instr_word[7:0] == CODE_WRITE_DISPLAY_B[7:0]
      && instr_word != CODE_WRITE_DISPLAY_B |=> $stable(cfg_out.display_cfg_b))
    else $error("partial word match wrote display register b");

  page_alias_a: assert property (
    instr_valid && instr_word[7:0] == CODE_WRITE_PAGE[7:0]
      && instr_word != CODE_WRITE_PAGE |=> $stable(page_ptr_q))
    else $error("partial word match wrote page pointer");

  // a bus write to the accumulator only lands when no instruction loads it too
  acc_bus_write_a: assert property (
    acc_bus_write_s ##0 !(instr_valid && (instr_word == CODE_READ_PULLUP_2
      || instr_word == CODE_READ_PAGE)) |=> acc_q == $past(hwdata[NIB_W-1:0]))
    else $error("bus write to accumulator lost");

  pullup_bus_write_a: assert property (
    req_q.valid && req_q.write && req_q.addr == ADDR_PULLUP_2
      |=> pullup_2_q == $past(hwdata[NIB_W-1:0]))
    else $error("bus write to pull-up register lost");

  done_clear_a: assert property (
    !instr_valid |=> !exec_done_q)
    else $error("done pulse without an instruction word");

endmodule : acc_ctrl_reg_transfer_decode
`default_nettype wire

/* testbench/instr_seq_model.sv */
// program sequencer model handing fetched words to the transfer block
`timescale 1ns/1ps
`default_nettype none
module instr_seq_model
  import acc_xfer_pkg::*;
(
  // clock
  input  wire logic               hclk,
  // fetched word
  output var  logic               instr_valid,
  output var  logic [INSTR_W-1:0] instr_word
);
  // ==========================================================================
  // word issue
  initial begin
    instr_valid = 1'b0;
    instr_word  = 10'h3FF;
  end

  // back to back words, entry 0 first; idle word is the inverse of the last
  // so a decoder that ignores valid sees a wrong opcode, not a stale one
  task automatic issue(input logic [3:0][INSTR_W-1:0] ws, input int n);
    for (int i = 0; i < n; i++) begin
      instr_valid <= 1'b1;
      instr_word  <= ws[i];
      @(posedge hclk);
    end
    instr_valid <= 1'b0;
    instr_word  <= ~ws[n-1];
  endtask : issue
endmodule : instr_seq_model
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the accumulator control-register transfer block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import acc_xfer_pkg::*;
;
  // ==========================================================================
  // signals
  logic                          hclk = 1'b0;
  logic                          hresetn;
  logic                          hsel;
  logic                          hwrite;
  logic [1:0]                    htrans;
  logic [2:0]                    hsize;
  logic [31:0]                   haddr;
  logic [31:0]                   hwdata;
  logic [31:0]                   hrdata;
  logic                          hreadyout;
  logic                          hresp;
  logic                          instr_valid;
  logic [INSTR_W-1:0]            instr_word;
  logic [NIB_W-1:0]              acc_q;
  logic [PAGE_W-1:0]             page_ptr_q;
  logic                          exec_done_q;
  logic                          skip_next_q;
  logic                          carry_we_q;
  cfg_out_type                   cfg_out;
  logic [CFG_N-1:0][NIB_W-1:0]   bank = '0;
  int                            bad_count = 0;
  int                            compares = 0;
  int                            cycles = 0;

  // write codes in slot order, slot 0 lowest
  localparam logic [CFG_N-1:0][INSTR_W-1:0] WCODE = {
    CODE_WRITE_WAKEUP_3, CODE_WRITE_WAKEUP_2,
    CODE_WRITE_WAKEUP_1, CODE_WRITE_WAKEUP_0,
    CODE_WRITE_DRIVE, CODE_WRITE_IRQ,
    CODE_WRITE_DISPLAY_D, CODE_WRITE_DISPLAY_C,
    CODE_WRITE_DISPLAY_B, CODE_WRITE_DISPLAY_A};

  always #10 hclk = ~hclk;

  acc_ctrl_reg_transfer_decode dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .instr_valid(instr_valid), .instr_word(instr_word), .acc_q(acc_q),
    .page_ptr_q(page_ptr_q), .exec_done_q(exec_done_q), .skip_next_q(skip_next_q),
    .carry_we_q(carry_we_q), .cfg_out(cfg_out));

  instr_seq_model seq_u (.hclk(hclk), .instr_valid(instr_valid), .instr_word(instr_word));

  // ==========================================================================
  // checking and verdict
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic check_core(input logic [NIB_W-1:0] ea, input logic [PAGE_W-1:0] ep,
                            input logic ed);
    check("acc", 40'(acc_q), 40'(ea));
    check("page", 40'(page_ptr_q), 40'(ep));
    check("cfg", 40'(cfg_out), 40'(bank));
    check("done", 40'(exec_done_q), 40'(ed));
    check("skip", 40'(skip_next_q), 40'h0);
    check("carry", 40'(carry_we_q), 40'h0);
  endtask : check_core

  task give_verdict;
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // hang guard, the whole run needs about 130 cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ==========================================================================
  // bus master, called just after a rising edge
  task automatic ahb_xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                          output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check("resp", 40'(hresp), 40'(HRESP_OKAY));
  endtask : ahb_xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb_xfer(a, 1'b1, d, rd);
  endtask : wr

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb_xfer(a, 1'b0, 32'h0, rd);
    check(name, 40'(rd), 40'(exp));
  endtask : rd_chk

  // ==========================================================================
  // scenarios
  task automatic xfer_each;
    logic [NIB_W-1:0] v;
    for (int i = 0; i < CFG_N; i++) begin
      v = 4'(i + 6);
      wr(ADDR_ACC, 32'(v));
      seq_u.issue({30'h0, WCODE[i]}, 1);
      bank[i] = v;
      @(negedge hclk);
      check_core(v, 3'h0, 1'b1);
      @(negedge hclk);
      check("done pulse", 40'(exec_done_q), 40'h0);
      @(posedge hclk);
    end
  endtask : xfer_each

  // load from pull-up register, then write it out on the very next word
  task automatic pullup_chain;
    wr(ADDR_PULLUP_2, 32'h0000_000A);
    wr(ADDR_ACC, 32'h0000_0003);
    seq_u.issue({20'h0, CODE_WRITE_DISPLAY_A, CODE_READ_PULLUP_2}, 2);
    bank[SLOT_DISPLAY_A] = 4'hA;
    @(negedge hclk);
    check_core(4'hA, 3'h0, 1'b1);
    @(posedge hclk);
    rd_chk("acc rd", ADDR_ACC, 32'h0000_000A);
    rd_chk("pullup rd", ADDR_PULLUP_2, 32'h0000_000A);
    rd_chk("display rd", ADDR_DISPLAY, 32'h0000_987A);
    rd_chk("wakeup rd", ADDR_WAKEUP, 32'h0000_FEDC);
    rd_chk("port irq rd", ADDR_PORT_IRQ, 32'h0000_00BA);
  endtask : pullup_chain

  task automatic page_test;
    wr(ADDR_ACC, 32'h0000_000F);
    seq_u.issue({30'h0, CODE_WRITE_PAGE}, 1);
    @(negedge hclk);
    check_core(4'hF, 3'h7, 1'b1);
    @(posedge hclk);
    wr(ADDR_PAGE, 32'h0000_0000);
    wr(ADDR_ACC, 32'h0000_0008);
    seq_u.issue({30'h0, CODE_READ_PAGE}, 1);
    @(negedge hclk);
    check_core(4'h7, 3'h7, 1'b1);
    @(posedge hclk);
    rd_chk("page reg", ADDR_PAGE, 32'h0000_0007);
    rd_chk("last op", ADDR_LAST_OP, 32'h0000_1000);
    rd_chk("unmapped", 32'h0000_001C, 32'h0000_0000);
    // write then read back on consecutive words, bit 3 of the source set
    wr(ADDR_ACC, 32'h0000_000D);
    seq_u.issue({20'h0, CODE_READ_PAGE, CODE_WRITE_PAGE}, 2);
    @(negedge hclk);
    check_core(4'h5, 3'h5, 1'b1);
    @(posedge hclk);
  endtask : page_test

  // words one bit away from real codes, top bits included
  task automatic near_miss;
    seq_u.issue({10'h0A8, 10'h3A9, 10'h229, 10'h05F}, 4);
    @(negedge hclk);
    check_core(4'h5, 3'h5, 1'b0);
    @(posedge hclk);
    seq_u.issue({10'h00A, 10'h30A, 10'h21A, 10'h251}, 4);
    @(negedge hclk);
    check_core(4'h5, 3'h5, 1'b0);
    @(posedge hclk);
  endtask : near_miss

  // reset in mid-run, then a bus write and a word right after release
  task automatic reset_mid;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bank = '0;
    @(negedge hclk);
    check_core(4'h0, 3'h0, 1'b0);
    check("hrdata rst", 40'(hrdata), 40'h0);
    @(posedge hclk);
    rd_chk("display rst", ADDR_DISPLAY, 32'h0000_0000);
    wr(ADDR_ACC, 32'h0000_0003);
    seq_u.issue({30'h0, CODE_WRITE_DISPLAY_B}, 1);
    bank[SLOT_DISPLAY_B] = 4'h3;
    @(negedge hclk);
    check_core(4'h3, 3'h0, 1'b1);
    @(posedge hclk);
  endtask : reset_mid

  // ==========================================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0000_0000;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0000_0000;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check_core(4'h0, 3'h0, 1'b0);
    check("ready", 40'(hreadyout), 40'h1);
    @(posedge hclk);
    xfer_each();
    pullup_chain();
    page_test();
    near_miss();
    reset_mid();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
